// ==== frgl_params.svh ====
// constants of the fast receive gain serial loader
// assumes inclusion by both ends, the package and the bench
`ifndef FRGL_PARAMS_SVH
`define FRGL_PARAMS_SVH
`define FRGL_FRAME_BITS 12
`define FRGL_GAIN_LSB 0
`define FRGL_GAIN_BITS 10
`define FRGL_CORNER_LSB 10
`define FRGL_CORNER_BITS 2
`define FRGL_CNT_BITS 4
`define FRGL_REG_GAIN_RST 12'h000
`define FRGL_CLK_DIV 5
`define FRGL_OFS_CTRL 4'h0
`define FRGL_OFS_DATA 4'h4
`define FRGL_OFS_STAT 4'h8
`define FRGL_OFS_GAIN 4'hC
`endif

// ==== frgl_pkg.sv ====
// types used by the controller end
// assumes frgl_params.svh beside it
`include "frgl_params.svh"
package frgl_pkg;
  typedef logic [`FRGL_FRAME_BITS-1:0] frgl_word_t;
  typedef enum logic [1:0] {FRGL_IDLE, FRGL_SETUP, FRGL_SHIFT, FRGL_DONE} frgl_hst_t;
endpackage

// ==== frgl_if.sv ====
// link between the gain loader device and its controller
// assumes the controller makes the serial clock
`timescale 1ns/1ps
interface frgl_if;
  logic serClk;
  logic busSelect;
  logic gainData;
  modport dev (input serClk, input busSelect, input gainData);
  modport host (output serClk, output busSelect, output gainData);
endinterface

// ==== frgl_host.sv ====
// controller end: avalon-mm slave that shifts gain frames out
// assumes mclk at 125 MHz; link clock derived by divider
`timescale 1ns/1ps
`include "frgl_params.svh"
module frgl_host #(
  parameter int CLK_DIV = `FRGL_CLK_DIV
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  frgl_if.host             link
);
  typedef struct packed {
    frgl_pkg::frgl_hst_t st;
    logic [7:0]  div;
    logic [3:0]  cnt;
    frgl_pkg::frgl_word_t sh;
    frgl_pkg::frgl_word_t last;
    logic        fastMode;
    logic        sclk;
    logic        sel;
    logic        dat;
    logic [31:0] rd;
    logic        ack;
  } frgl_hstate_t;
  frgl_hstate_t s_r, s_nxt;
  logic busy;
  assign busy = (s_r.st != frgl_pkg::FRGL_IDLE);
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    // first cycle latches read data; writes commit only when waitrequest is low
    if ((avsRead || avsWrite) && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.rd = 32'h0000_0000;
      if (avsRead) begin
        unique case (avsAddress)
          `FRGL_OFS_CTRL: s_nxt.rd = {31'h0, s_r.fastMode};
          `FRGL_OFS_STAT: s_nxt.rd = {31'h0, busy};
          `FRGL_OFS_GAIN: s_nxt.rd = {20'h0, s_r.last};
          default:        s_nxt.rd = 32'h0000_0000;
        endcase
      end
    end
    if (avsWrite && s_r.ack) begin
      if (avsAddress == `FRGL_OFS_CTRL) begin
        s_nxt.fastMode = avsWritedata[0];
      end else if (avsAddress == `FRGL_OFS_DATA && !busy && s_r.fastMode) begin
        s_nxt.sh   = avsWritedata[`FRGL_FRAME_BITS-1:0];
        s_nxt.last = avsWritedata[`FRGL_FRAME_BITS-1:0];
        s_nxt.st   = frgl_pkg::FRGL_SETUP;
        s_nxt.div  = 8'h00;
        s_nxt.sel  = 1'b1;
      end
    end
    unique case (s_r.st)
      frgl_pkg::FRGL_IDLE: ;
      frgl_pkg::FRGL_SETUP: begin
        s_nxt.div = s_r.div + 8'h01;
        if (s_r.div == 8'(CLK_DIV - 1)) begin
          s_nxt.div = 8'h00;
          s_nxt.dat = s_r.sh[0];
          s_nxt.sh  = s_r.sh >> 1;
          s_nxt.cnt = 4'h0;
          s_nxt.st  = frgl_pkg::FRGL_SHIFT;
        end
      end
      frgl_pkg::FRGL_SHIFT: begin
        s_nxt.div = s_r.div + 8'h01;
        if (s_r.div == 8'(CLK_DIV - 1)) begin
          s_nxt.div  = 8'h00;
          s_nxt.sclk = ~s_r.sclk;
          if (s_r.sclk) begin
            s_nxt.dat = s_r.sh[0];
            s_nxt.sh  = s_r.sh >> 1;
          end else begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == 4'(`FRGL_FRAME_BITS - 1)) s_nxt.st = frgl_pkg::FRGL_DONE;
          end
        end
      end
      frgl_pkg::FRGL_DONE: begin
        s_nxt.div = s_r.div + 8'h01;
        if (s_r.div == 8'(CLK_DIV - 1)) begin
          s_nxt.sclk = 1'b0;
          s_nxt.sel  = 1'b0;
          s_nxt.st   = frgl_pkg::FRGL_IDLE;
        end
      end
    endcase
    if (rst) s_nxt = '0;
  end
  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end
  assign avsWaitrequest = (avsRead || avsWrite) && !s_r.ack;
  assign avsReaddata    = s_r.rd;
  assign link.serClk    = s_r.sclk;
  assign link.busSelect = s_r.sel;
  assign link.gainData  = s_r.dat;
endmodule // frgl_host

// ==== frgl_dev.sv ====
// device end: fast serial receive gain loader
// assumes serClk from the controller; mclk domain runs the receiver side
`timescale 1ns/1ps
`include "frgl_params.svh"
module frgl_dev #(
  parameter int FRAME_BITS = `FRGL_FRAME_BITS
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  frgl_if.dev                  link,
  input  wire logic            fastMode,
  input  wire logic [9:0]      agcGain,
  output logic                 agcEnable,
  output logic                 regBusEnable,
  output logic [9:0]           rxGain,
  output logic [1:0]           dcCorner,
  output logic                 loadPulse
);
  typedef struct packed {
    logic [FRAME_BITS-1:0]       sh;
    logic [FRAME_BITS-1:0]       hold;
  } frgl_lstate_t;
  typedef struct packed {
    logic [`FRGL_CNT_BITS-1:0]   cnt;
    logic                        done;
  } frgl_lctl_t;
  typedef struct packed {
    logic [2:0]            togSync;
    logic [1:0]            modeSync;
    logic [FRAME_BITS-1:0] cap;
    logic [9:0]            gain;
    logic [1:0]            corner;
    logic                  pulse;
  } frgl_mstate_t;
  frgl_lstate_t l_r, l_nxt;
  frgl_lctl_t   c_r, c_nxt;
  frgl_mstate_t m_r, m_nxt;
  logic modeLink1, modeLink2;
  logic active;
  // fast mode crosses into the link domain before gating shifts
  always_ff @(posedge link.serClk) begin
    modeLink1 <= fastMode;
    modeLink2 <= modeLink1;
  end
  assign active = modeLink2 && link.busSelect;
  always_comb begin
    l_nxt      = l_r;
    c_nxt      = c_r;
    c_nxt.done = 1'b0;
    if (active) begin
      l_nxt.sh  = {link.gainData, l_r.sh[FRAME_BITS-1:1]};
      c_nxt.cnt = c_r.cnt + 1'b1;
      if (c_r.cnt == `FRGL_CNT_BITS'(FRAME_BITS - 1)) begin
        l_nxt.hold = {link.gainData, l_r.sh[FRAME_BITS-1:1]};
        c_nxt.done = 1'b1;
        c_nxt.cnt  = '0;
      end
    end
  end
  // select low clears the count at once: the link clock is parked between frames
  always_ff @(posedge link.serClk or negedge link.busSelect) begin
    if (!link.busSelect) c_r <= '0;
    else c_r <= c_nxt;
  end
  // shift data needs no reset: only a full frame reaches the holding register
  always_ff @(posedge link.serClk) begin
    l_r <= l_nxt;
  end
  // done stands until select falls, several mclk cycles; hold is stable far longer
  always_comb begin
    m_nxt = m_r;
    m_nxt.togSync  = {m_r.togSync[1:0], c_r.done};
    m_nxt.modeSync = {m_r.modeSync[0], fastMode};
    m_nxt.pulse    = m_r.togSync[1] & ~m_r.togSync[2];
    if (m_r.togSync[1] & ~m_r.togSync[2]) begin
      m_nxt.cap = l_r.hold;
    end
    if (fastMode) begin
      m_nxt.gain   = m_nxt.cap[`FRGL_GAIN_LSB +: `FRGL_GAIN_BITS];
      m_nxt.corner = m_nxt.cap[`FRGL_CORNER_LSB +: `FRGL_CORNER_BITS];
    end else begin
      m_nxt.gain   = agcGain;
      m_nxt.corner = m_r.corner;
    end
    if (rst) m_nxt = '0;
  end
  always_ff @(posedge mclk) begin
    m_r <= m_nxt;
  end
  assign agcEnable    = !fastMode;
  assign regBusEnable = !link.busSelect;
  assign rxGain       = m_r.gain;
  assign dcCorner     = m_r.corner;
  assign loadPulse    = m_r.pulse;
endmodule // frgl_dev

// ==== frgl_properties.sv ====
// wire checks of the fast gain link
// assumes CLK_DIV of 5, one frame at a time
`timescale 1ns/1ps
module frgl_link_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serClk,
  input wire logic busSelect,
  input wire logic gainData
);
  logic [4:0] edgeCnt_r;
  logic       clkPrev_r;
  always_ff @(posedge mclk) begin
    clkPrev_r <= serClk;
    if (rst || !busSelect) edgeCnt_r <= 5'h00;
    else if (serClk && !clkPrev_r) edgeCnt_r <= edgeCnt_r + 5'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_clock_parked: assert property (!busSelect |-> !serClk)
    else $error("clock runs unselected");
  a_select_lead: assert property ($rose(busSelect) |-> !serClk[*4])
    else $error("clock too soon after select");
  a_data_steady: assert property ($rose(serClk) |-> $stable(gainData))
    else $error("data moved at rising edge");
  a_high_width: assert property ($rose(serClk) |-> serClk[*5] ##1 !serClk)
    else $error("clock high width");
  a_low_width: assert property ($fell(serClk) && busSelect |-> !serClk[*5])
    else $error("clock low width");
  a_twelve_edges: assert property ($fell(busSelect) |-> edgeCnt_r == 5'h0C)
    else $error("frame not twelve bits");
  a_edge_ceiling: assert property (edgeCnt_r <= 5'h0C)
    else $error("too many edges");
  a_frame_ends: assert property ($rose(busSelect) |-> ##[100:200] !busSelect)
    else $error("frame never ends");
endmodule // frgl_link_checker

// ==== fast_rx_gain_serial_loader_tb.sv ====
// bench: avalon side of the controller, receiver side of the device
// assumes the two ends meet in frgl_if
`timescale 1ns/1ps
`include "frgl_params.svh"
module fast_rx_gain_serial_loader_tb;
  logic mclk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, fastMode = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, q;
  logic avsWaitrequest, agcEnable, regBusEnable, loadPulse;
  logic [9:0] agcGain = 10'h155, rxGain;
  logic [1:0] dcCorner;
  logic [11:0] words [4] = '{12'hA5C, 12'h3FF, 12'hC01, 12'h800};
  int miscompares = 0, checks_done = 0, loads = 0, cycles = 0;
  frgl_if link ();
  frgl_host frgl_host_i (.mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .link(link));
  frgl_dev frgl_dev_i (.mclk(mclk), .rst(rst), .link(link), .fastMode(fastMode),
    .agcGain(agcGain), .agcEnable(agcEnable), .regBusEnable(regBusEnable),
    .rxGain(rxGain), .dcCorner(dcCorner), .loadPulse(loadPulse));
  frgl_link_checker frgl_link_checker_i (.mclk(mclk), .rst(rst), .serClk(link.serClk),
    .busSelect(link.busSelect), .gainData(link.gainData));
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (loadPulse === 1'b1) loads++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest seen low at an edge
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsWrite <= wr;
    avsRead <= !wr;
    avsAddress <= a;
    avsWritedata <= d;
    @(posedge mclk);
    while (avsWaitrequest !== 1'b0) @(posedge mclk);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic frame(input logic [11:0] w);
    acc(1'b1, `FRGL_OFS_DATA, {20'h00000, w});
    acc(1'b0, `FRGL_OFS_STAT, 32'h0);
    while (q[0] !== 1'b0) begin
      if (link.busSelect === 1'b1) chk(regBusEnable, 1'b0);
      acc(1'b0, `FRGL_OFS_STAT, 32'h0);
    end
    repeat (8) @(posedge mclk);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(agcEnable, 1'b1);
    frame(12'h0F0);
    chk(rxGain, 10'h155);
    $display("test gain loop done");
    acc(1'b1, `FRGL_OFS_CTRL, 32'h1);
    fastMode <= 1'b1;
    // first frame only lets the mode settle in the link domain
    frame(12'h000);
    loads = 0;
    chk(agcEnable, 1'b0);
    for (int i = 0; i < 4; i++) begin
      frame(words[i]);
      chk({dcCorner, rxGain}, words[i]);
      acc(1'b0, `FRGL_OFS_GAIN, 32'h0);
      chk(q, {20'h00000, words[i]});
    end
    chk(loads, 4);
    acc(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    chk(regBusEnable, 1'b1);
    $display("test fast frames done");
    conclude();
  end
endmodule // fast_rx_gain_serial_loader_tb
